// file: dv/acs_comp_model.sv
// Comparator and sample-hold model that faces the sequencer's analog side.
// Assumes inputs are given in half-step units of the reference, 0 to 510.
`default_nettype none
module acs_comp_model (
	input wire logic clk_i, // Main clock
	input wire acs_pkg::acs_analog_t analog_i, // Channel, sample, tap
	input wire logic [71:0] vin_i, // Eight inputs, 9 bits each
	output logic comp_o // Input at or above tap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] live; // Selected input voltage
	logic [8:0] held; // Held voltage
	// Multiplexer follows the channel code
	assign live = vin_i[analog_i.channel * 9 +: 9];
	// Track while sampling, hold during the decisions
	always_ff @(posedge clk_i) begin
		if (analog_i.sample) begin
			held <= live;
		end
	end
	// Tap sits half a step low, so the search rounds to nearest
	assign comp_o = (10'(held) + 10'h001) >= {1'b0, analog_i.tap, 1'b0};
endmodule : acs_comp_model
`default_nettype wire

// file: dv/adc_conversion_sequencer_bench.sv
// Self-checking bench of the conversion sequencer against a result model.
// Assumes the comparator model file and the design under logic/.
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %0t got %0h want %0h", $time, g, e); end end
module adc_conversion_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, reset_i, rd, wr, trig, waitreq, comp, ref_open, done, busy; // Bench nets
	logic [3:0] addr; // Bus address
	logic [31:0] wdata, rdata, q; // Bus data, last read
	logic [71:0] vin; // Packed analog inputs
	logic [15:0] seed; // Random state
	acs_pkg::acs_analog_t analog; // Analog side
	int v[8]; // Model input voltages
	int n_fail, compares, n_done, t_done, cyc, t0, t1, n, c; // Counters
	logic [7:0] m; // Mode value
	////////////////////////////////////////////////////////////////////////////
	acs_top dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .ext_trigger_input_i(trig),
		.comp_i(comp), .analog_o(analog), .ref_switch_open_o(ref_open),
		.conv_done_request_o(done), .busy_o(busy));
	acs_comp_model far (.clk_i(clk_i), .analog_i(analog), .vin_i(vin), .comp_o(comp));
	////////////////////////////////////////////////////////////////////////////
	// Clock, cycle count and completion monitor
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (done === 1'b1) begin
			n_done <= n_done + 1;
			t_done <= cyc;
		end
	end
	// Sixteen-bit shift register for random voltages
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Model result: rounded input over reference times 256
	function automatic logic [7:0] expv(input int ch);
		return 8'((v[ch] + 1) / 2);
	endfunction : expv
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h000000, d};
		// No local limit: a slave that never answers is caught by the watchdog
		do begin
			@(posedge clk_i);
		end while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	// Wait for the next completion, bounded
	task automatic wait_done(output int t);
		int k;
		int s;
		s = n_done;
		k = 0;
		while (n_done == s && k < 400) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 400) n_fail++;
		t = t_done;
	endtask : wait_done
	// One-cycle trigger pulse
	task automatic pulse;
		@(posedge clk_i);
		trig <= 1'b1;
		@(posedge clk_i);
		trig <= 1'b0;
	endtask : pulse
	task automatic results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////
	// Watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge clk_i);
		n_fail++;
		results();
	end
	// Main sequence; only block registers are read, never a converting pin
	initial begin
		{rd, wr, trig, addr, wdata, n_fail, compares, n_done, t_done, cyc} = '0;
		reset_i = 1'b1;
		seed = 16'h004f;
		for (c = 0; c < 8; c++) begin
			seed = lfsr(seed);
			v[c] = seed % 511;
			vin[c * 9 +: 9] = 9'(v[c]);
		end
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		bus(1'b0, acs_pkg::ADDR_MODE, 8'h00);
		`CHK(q, 32'h00000001)
		bus(1'b0, acs_pkg::ADDR_REFSW, 8'h00);
		`CHK(q, 32'h00000000)
		bus(1'b1, acs_pkg::ADDR_REFSW, acs_pkg::REFSW_OPEN);
		@(posedge clk_i);
		`CHK(ref_open, 1'b1)
		bus(1'b1, acs_pkg::ADDR_REFSW, 8'h00);
		@(posedge clk_i);
		`CHK(ref_open, 1'b0)
		bus(1'b0, 4'h2, 8'h00);
		`CHK(q, 32'h00000000)
		// Software start on every channel, both time codes
		for (c = 0; c < 8; c++) begin
			m = 8'h81 | 8'(c << 1) | (c[0] ? 8'h20 : 8'h00);
			bus(1'b1, acs_pkg::ADDR_MODE, m);
			wait_done(t0);
			bus(1'b0, acs_pkg::ADDR_RESULT, 8'h00);
			`CHK(q[7:0], expv(c))
			`CHK(analog.channel, 3'(c))
			wait_done(t1);
			`CHK(t1 - t0, c[0] ? 100 : 80)
		end
		bus(1'b0, acs_pkg::ADDR_FLAG, 8'h00);
		`CHK(q[0], 1'b1)
		// Restart mid-conversion on another channel
		repeat (30) @(posedge clk_i);
		bus(1'b1, acs_pkg::ADDR_MODE, 8'h8b);
		bus(1'b0, acs_pkg::ADDR_FLAG, 8'h00);
		`CHK(q[0], 1'b1)
		bus(1'b1, acs_pkg::ADDR_FLAG, 8'h01);
		bus(1'b0, acs_pkg::ADDR_FLAG, 8'h00);
		`CHK(q[0], 1'b0)
		wait_done(t0);
		bus(1'b0, acs_pkg::ADDR_RESULT, 8'h00);
		`CHK(q[7:0], expv(5))
		// Stop with the run bit cleared
		repeat (20) @(posedge clk_i);
		bus(1'b1, acs_pkg::ADDR_MODE, 8'h01);
		@(posedge clk_i);
		`CHK(busy, 1'b0)
		n = n_done;
		repeat (200) @(posedge clk_i);
		`CHK(n_done, n)
		// Trigger mode: standby, one conversion per trigger
		bus(1'b1, acs_pkg::ADDR_MODE, 8'hc7);
		repeat (150) @(posedge clk_i);
		`CHK(n_done, n)
		`CHK(busy, 1'b0)
		pulse();
		t1 = cyc;
		repeat (40) @(posedge clk_i);
		pulse();
		wait_done(t0);
		`CHK(t0 - t1, acs_pkg::CONV_CLKS_80 + 1)
		n = n_done;
		bus(1'b0, acs_pkg::ADDR_RESULT, 8'h00);
		`CHK(q[7:0], expv(3))
		repeat (200) @(posedge clk_i);
		`CHK(n_done, n)
		// Rewrite in trigger mode aborts and waits
		pulse();
		repeat (30) @(posedge clk_i);
		bus(1'b1, acs_pkg::ADDR_MODE, 8'hc7);
		repeat (150) @(posedge clk_i);
		`CHK(n_done, n)
		`CHK(busy, 1'b0)
		pulse();
		wait_done(t0);
		bus(1'b0, acs_pkg::ADDR_RESULT, 8'h00);
		`CHK(q[7:0], expv(3))
		results();
	end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire

// file: logic/acs_pkg.sv
// Constants, register map and carrier types of the conversion sequencer.
// Assumes a 20 MHz main clock and an Avalon-MM slave with 32-bit data.
`default_nettype none
package acs_pkg;
	// Register word byte addresses
	localparam logic [3:0] ADDR_MODE = 4'h0; // conv_mode_reg
	localparam logic [3:0] ADDR_RESULT = 4'h4; // conv_result_reg
	localparam logic [3:0] ADDR_FLAG = 4'h8; // conv_done_flag, write 1 clears
	localparam logic [3:0] ADDR_REFSW = 4'hc; // ref_switch_reg
	// Mode register fields
	localparam int RUN_BIT = 7; // Run bit
	localparam int TRIG_BIT = 6; // hw_trigger_select
	localparam int TIME_HI_BIT = 5; // conv_time_hi
	localparam int TIME_LO_BIT = 4; // conv_time_lo
	localparam int CHAN_MSB = 3; // channel_select_field top
	localparam int CHAN_LSB = 1; // channel_select_field bottom
	localparam int SPEED_BIT = 0; // conv_time_speed
	localparam logic [7:0] MODE_RESET = 8'h01; // Mode after reset
	localparam logic [7:0] REFSW_RESET = 8'h00; // Switch closed after reset
	localparam logic [7:0] REFSW_OPEN = 8'h01; // Switch open value
	// Conversion time codes {hi,lo,speed}
	localparam logic [2:0] TCODE_80 = 3'h1; // 80 clock periods
	localparam logic [2:0] TCODE_100 = 3'h5; // 100 clock periods
	localparam int CONV_CLKS_80 = 80; // Conversion length, short code
	localparam int CONV_CLKS_100 = 100; // Conversion length, long code
	localparam int STEP_CLKS = 8; // Cycles per bit decision
	localparam int BITS = 8; // Result width
	// Sampling length derived so that sampling plus 8 steps fills the time
	localparam logic [6:0] SAMPLE_80 = 7'(CONV_CLKS_80 - BITS * STEP_CLKS);
	localparam logic [6:0] SAMPLE_100 = 7'(CONV_CLKS_100 - BITS * STEP_CLKS);
	localparam logic [6:0] STEP_LEN = 7'(STEP_CLKS);

	// Sequencer states
	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_WAIT_TRIG,
		ACS_SAMPLE,
		ACS_STEP
	} acs_state_t;

	// Analog side carrier
	typedef struct packed {
		logic [2:0] channel; // Selected analog input
		logic sample; // Sample-hold tracking
		logic [7:0] tap; // Tap selector code
	} acs_analog_t;
endpackage : acs_pkg
`default_nettype wire

// file: logic/acs_sar.sv
// Successive approximation bit register: one decision per step, msb first.
// Assumes the comparator output is settled when step_i pulses.
`default_nettype none
module acs_sar (
	input wire logic clk_i, // Main clock
	input wire logic reset_i, // Sync reset, active high
	input wire logic clear_i, // Begin a new approximation
	input wire logic step_i, // Take one comparator decision
	input wire logic comp_i, // Input at or above tap
	output logic [7:0] trial_o, // Current tap code
	output logic last_o // Decision on bit 0 pending
);
	logic [7:0] approx_bit_register; // Kept bits
	logic [7:0] probe; // One-hot bit under trial
	logic [7:0] next_approx;
	logic [7:0] next_probe;

	// Next approximation
	always_comb begin
		next_approx = approx_bit_register;
		next_probe = probe;
		if (clear_i) begin
			next_approx = 8'h00;
			next_probe = 8'h80;
		end else if (step_i) begin
			// Keep or drop the trial bit, move down [R20]
			if (comp_i) begin
				next_approx = approx_bit_register | probe;
			end
			next_probe = {1'b0, probe[7:1]};
		end
	end

	// Register stage
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			approx_bit_register <= 8'h00;
			probe <= 8'h80;
		end else begin
			approx_bit_register <= next_approx;
			probe <= next_probe;
		end
	end

	assign trial_o = approx_bit_register | probe;
	assign last_o = probe[0];
endmodule : acs_sar
`default_nettype wire

// file: logic/acs_top.sv
// Conversion sequencer for an 8-channel 8-bit successive approximation converter.
// Assumes an external comparator and tap selector, a one-cycle trigger pulse and
// an Avalon-MM master; the block runs only on the main system clock.
//
// What this block does
// (R1) Convert repeatedly until run bit cleared
// (R2) Mode write reinitialises any conversion
// (R3) Result register needs no reset value
// (R4) Result equals rounded input over reference
// (R5) Mode bits 1..3 pick the channel
// (R6) Trigger mode waits in standby
// (R7) Trigger mode converts once per trigger
// (R8) Trigger mode write aborts, awaits trigger
// (R9) Run bit zero write stops at once
// (R10) Software mode starts without waiting
// (R11) Software mode converts back to back
// (R12) Software mode write restarts with new settings
// (R13) Result load and done request together
// (R14) Mode write leaves done flag alone
// (R15) Software clears flag before restarting
// (R16) Runs from main clock only
// (R17) Switch register 00 closes, 01 opens
// (R18) Software avoids port reads while converting
// (R19) Mode resets to 01H
// (R20) Eight decisions, bit 7 to 0
// (R21) Time codes give 80 or 100 cycles
// (R22) Cycle counter paces sample and steps
// (R23) Trigger pulses outside standby ignored
//
// The address map and the Avalon-MM slave port were decided locally.
`default_nettype none
module acs_top (
	input wire logic clk_i, // Main system clock, 20 MHz
	input wire logic reset_i, // Sync reset, active high
	input wire logic [3:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Byte lanes
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall
	input wire logic ext_trigger_input_i, // One-cycle trigger pulse
	input wire logic comp_i, // Input at or above tap
	output acs_pkg::acs_analog_t analog_o, // Channel, sample, tap
	output logic ref_switch_open_o, // Reference switch open
	output logic conv_done_request_o, // One-cycle completion pulse
	output logic busy_o // Conversion in progress
);
	////////////////////////////////////////////////////////////////////////
	// Bus slave
	logic [7:0] conv_mode_reg; // Mode register
	logic [7:0] conv_result_reg; // Result register
	logic conv_done_flag; // Sticky completion flag
	logic [7:0] ref_switch_reg; // Reference switch register
	logic ack; // Answer phase
	logic [31:0] rdata; // Read data register
	logic [7:0] next_mode;
	logic [7:0] next_refsw;
	logic next_ack;
	logic [31:0] next_rdata;
	logic mode_wr; // Mode written this cycle
	logic flag_clr; // Flag clear request
	logic req; // Request not yet answered
	logic stall; // Registered waitrequest, high while no answer stands

	assign req = (avs_read_i | avs_write_i) & ~ack;

	// Decode and register writes; answer one cycle after the request
	always_comb begin
		next_mode = conv_mode_reg;
		next_refsw = ref_switch_reg;
		next_ack = req;
		next_rdata = rdata;
		mode_wr = 1'b0;
		flag_clr = 1'b0;
		if (req && avs_write_i && avs_byteenable_i[0]) begin
			if (avs_address_i == acs_pkg::ADDR_MODE) begin
				next_mode = avs_writedata_i[7:0];
				mode_wr = 1'b1;
			end else if (avs_address_i == acs_pkg::ADDR_FLAG) begin
				flag_clr = avs_writedata_i[0];
			end else if (avs_address_i == acs_pkg::ADDR_REFSW) begin
				next_refsw = avs_writedata_i[7:0]; // [R17]
			end
		end
		if (req && avs_read_i) begin
			if (avs_address_i == acs_pkg::ADDR_MODE) begin
				next_rdata = {24'h000000, conv_mode_reg};
			end else if (avs_address_i == acs_pkg::ADDR_RESULT) begin
				next_rdata = {24'h000000, conv_result_reg};
			end else if (avs_address_i == acs_pkg::ADDR_FLAG) begin
				next_rdata = {31'h00000000, conv_done_flag};
			end else if (avs_address_i == acs_pkg::ADDR_REFSW) begin
				next_rdata = {24'h000000, ref_switch_reg};
			end else begin
				// Unmapped reads return zero
				next_rdata = 32'h00000000;
			end
		end
	end

	// Register stage of the slave
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			conv_mode_reg <= acs_pkg::MODE_RESET; // [R19]
			ref_switch_reg <= acs_pkg::REFSW_RESET;
			ack <= 1'b0;
			stall <= 1'b1;
			rdata <= 32'h00000000;
		end else begin
			conv_mode_reg <= next_mode;
			ref_switch_reg <= next_refsw;
			ack <= next_ack;
			stall <= ~next_ack;
			rdata <= next_rdata;
		end
	end

	assign avs_readdata_o = rdata;
	assign avs_waitrequest_o = stall;

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	acs_pkg::acs_state_t state; // Sequencer state
	acs_pkg::acs_state_t next_state;
	logic [6:0] count; // Cycle counter
	logic [6:0] next_count;
	logic sar_clear; // Start new approximation
	logic sar_step; // Take a decision
	logic [7:0] trial; // Tap code under trial
	logic sar_last; // Bit 0 under trial
	logic done; // Completion this cycle
	logic [6:0] sample_len; // Sampling length for code
	logic run_new; // Run bit of the written value
	logic trig_new; // Trigger select of the written value

	assign run_new = avs_writedata_i[acs_pkg::RUN_BIT];
	assign trig_new = avs_writedata_i[acs_pkg::TRIG_BIT];

	// Sampling length from the time code, which is 80 or 100 cycles [R21]
	always_comb begin
		if ({conv_mode_reg[acs_pkg::TIME_HI_BIT], conv_mode_reg[acs_pkg::TIME_LO_BIT],
			conv_mode_reg[acs_pkg::SPEED_BIT]} == acs_pkg::TCODE_100) begin
			sample_len = acs_pkg::SAMPLE_100;
		end else begin
			// Prohibited codes fall back to the short time
			sample_len = acs_pkg::SAMPLE_80;
		end
	end

	// Next state of the sequencer
	always_comb begin
		next_state = state;
		next_count = count;
		sar_clear = 1'b0;
		sar_step = 1'b0;
		done = 1'b0;
		if (mode_wr) begin
			// Any mode write reinitialises the conversion [R2]
			sar_clear = 1'b1;
			next_count = 7'h00;
			if (!run_new) begin
				next_state = acs_pkg::ACS_IDLE; // [R9] [R1]
			end else if (trig_new) begin
				next_state = acs_pkg::ACS_WAIT_TRIG; // [R6] [R8]
			end else begin
				next_state = acs_pkg::ACS_SAMPLE; // [R10] [R12]
			end
		end else begin
			case (state)
				acs_pkg::ACS_IDLE: begin
					next_state = acs_pkg::ACS_IDLE;
				end
				acs_pkg::ACS_WAIT_TRIG: begin
					// Only a standby trigger starts work [R23]
					if (ext_trigger_input_i) begin
						next_state = acs_pkg::ACS_SAMPLE;
						next_count = 7'h00;
						sar_clear = 1'b1;
					end
				end
				acs_pkg::ACS_SAMPLE: begin
					// Count out the sampling time [R22]
					if (count == sample_len - 7'h01) begin
						next_state = acs_pkg::ACS_STEP;
						next_count = 7'h00;
					end else begin
						next_count = count + 7'h01;
					end
				end
				acs_pkg::ACS_STEP: begin
					if (count == acs_pkg::STEP_LEN - 7'h01) begin
						sar_step = 1'b1; // [R20]
						next_count = 7'h00;
						if (sar_last) begin
							done = 1'b1; // [R13]
							sar_clear = 1'b1;
							if (conv_mode_reg[acs_pkg::TRIG_BIT]) begin
								next_state = acs_pkg::ACS_WAIT_TRIG; // [R7]
							end else begin
								next_state = acs_pkg::ACS_SAMPLE; // [R11] [R1]
							end
						end
					end else begin
						next_count = count + 7'h01;
					end
				end
				default: begin
					next_state = acs_pkg::ACS_IDLE;
				end
			endcase
		end
	end

	// Register stage of the sequencer
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= acs_pkg::ACS_IDLE;
			count <= 7'h00;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// Bit decisions; the comparator makes the result the rounded ratio [R4]
	acs_sar u_sar (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.clear_i(sar_clear),
		.step_i(sar_step),
		.comp_i(comp_i),
		.trial_o(trial),
		.last_o(sar_last)
	);

	////////////////////////////////////////////////////////////////////////
	// Result, flag and outputs
	logic next_flag;
	logic [7:0] next_result;
	logic done_q; // Registered done pulse
	logic [7:0] final_code; // Code with last decision

	assign final_code = comp_i ? trial : (trial & 8'hfe);

	// Flag: completion wins over clear, mode writes do not touch it
	always_comb begin
		next_flag = conv_done_flag;
		next_result = conv_result_reg;
		if (flag_clr) begin
			next_flag = 1'b0;
		end
		if (done) begin
			next_flag = 1'b1; // [R14]
			next_result = final_code; // [R13]
		end
	end

	// Result has no reset value [R3]
	always_ff @(posedge clk_i) begin
		conv_result_reg <= next_result;
	end

	// Flag and output registers, main clock only [R16]
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			conv_done_flag <= 1'b0;
			done_q <= 1'b0;
			analog_o <= '0;
			ref_switch_open_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			conv_done_flag <= next_flag;
			done_q <= done;
			analog_o.channel <= next_mode[acs_pkg::CHAN_MSB:acs_pkg::CHAN_LSB]; // [R5]
			analog_o.sample <= (next_state == acs_pkg::ACS_SAMPLE);
			analog_o.tap <= trial;
			ref_switch_open_o <= (next_refsw == acs_pkg::REFSW_OPEN); // [R17]
			busy_o <= (next_state == acs_pkg::ACS_SAMPLE) ||
				(next_state == acs_pkg::ACS_STEP);
		end
	end

	assign conv_done_request_o = done_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	stop_on_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R9]
		mode_wr && !run_new |=> state == acs_pkg::ACS_IDLE)
		else $error("run bit clear did not stop");
	trig_standby_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
		mode_wr && run_new && trig_new |=> state == acs_pkg::ACS_WAIT_TRIG)
		else $error("trigger mode did not enter standby");
	sw_start_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
		mode_wr && run_new && !trig_new |=> state == acs_pkg::ACS_SAMPLE && count == 7'h00)
		else $error("software start did not begin sampling");
	done_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
		done |=> conv_done_request_o && conv_done_flag && conv_result_reg == $past(final_code))
		else $error("result and done request not together");
	flag_kept_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
		mode_wr && !flag_clr && conv_done_flag |=> conv_done_flag)
		else $error("mode write changed done flag");
	one_shot_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R7]
		done && conv_mode_reg[acs_pkg::TRIG_BIT] && !mode_wr |=> state == acs_pkg::ACS_WAIT_TRIG)
		else $error("trigger mode converted again without trigger");
	back_to_back_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
		done && !conv_mode_reg[acs_pkg::TRIG_BIT] && !mode_wr |=> state == acs_pkg::ACS_SAMPLE)
		else $error("software mode did not continue");
	ignore_trig_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R23]
		state == acs_pkg::ACS_IDLE && !mode_wr |=> state == acs_pkg::ACS_IDLE)
		else $error("idle left without mode write");
	step_pace_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R22]
		sar_step |-> $past(sar_step, 1) == 1'b0 && count == acs_pkg::STEP_LEN - 7'h01)
		else $error("bit step off pace");
endmodule : acs_top
`default_nettype wire
